// *** src/vpw_control.sv ***
// Operation
// - Sleep write ignores rest of message
// - Sleeping, not sending: only end-of-frame and break flags
// - End-of-frame or break clears sleep
// - Sleep write ignored after end-of-frame idle
// - Sleep in frame aborts queued response
// - Sleep while sending: receive flags suppressed
// - Normalization select swaps long/short forms
// - Polarity bit matches receive input sense
// - Loopback routes transmit internally, pins passive
// - Tick divides clock by field plus one
// - Enable and disable bits select mode
// - Enabled mode runs every feature
// - Suspended mode runs decoder only
// - Suspended forces status, error, sleep reset
// - Disabled stops decoder, then waits idle
// - Disabled also clears mask and pendings
// - Enable refused in disable-clearing write
// - Error events set error status; sleep and filtered frames hold off overrun
// - Passive line raises end-of-data/frame flags
// - Transmit ready on free or taken opcode
`timescale 1ns/1ps
module vpw_control (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ctrl_wr,
    input wire logic unit_enable_bit,
    input wire logic unit_disable_bit,
    input wire logic [5:0] timing_divider_reg,
    input wire logic normalization_select,
    input wire logic receive_polarity_bit,
    input wire logic internal_loopback_bit,
    input wire logic sleep_wr,
    input wire logic sleep_wdata,
    input wire logic mask_wr,
    input wire vpw_pkg::vpw_status_type mask_wdata,
    input wire vpw_pkg::vpw_status_type status_clr,
    input wire vpw_pkg::vpw_error_type error_clr,
    input wire logic rx_pend_clr,
    input wire logic tx_pend_clr,
    input wire logic bus_rx_in,
    output logic bus_tx_out,
    input wire logic enc_tx_level,
    input wire logic transmitting,
    input wire logic in_frame,
    input wire vpw_pkg::vpw_symbol_type dec_sym,
    input wire vpw_pkg::vpw_error_type err_evt,
    input wire logic lost_arb_evt,
    input wire logic rx_done_evt,
    input wire logic opcode_free_evt,
    input wire logic opcode_taken_evt,
    input wire logic frame_filtered,
    input wire logic rx_block_done_evt,
    input wire logic tx_block_done_evt,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    output logic rx_byte_ready,
    output logic rd_valid,
    output logic [7:0] rd_data,
    input wire logic rd_ready,
    output logic tick_1us,
    output logic decoder_run,
    output logic logic_run,
    output logic rx_line,
    output vpw_pkg::vpw_mode_type mode,
    output logic receive_sleep_bit,
    output logic ifr_abort,
    output vpw_pkg::vpw_status_type status,
    output vpw_pkg::vpw_error_type error,
    output vpw_pkg::vpw_status_type interrupt_mask_reg,
    output vpw_pkg::vpw_status_type irq_req,
    output logic receive_block_pending,
    output logic transmit_block_pending,
    output logic norm_symbol_with_check,
    output logic norm_symbol_no_check
);

    vpw_pkg::vpw_state_type r_reg;
    vpw_pkg::vpw_state_type r_next;
    logic quiet;
    logic rx_ok;
    logic buf_push;
    logic buf_ready;

    // Sleeping without sending keeps everything but break and end-of-frame quiet.
    assign quiet = r_reg.receive_sleep_bit && !transmitting;
    // Sleep or a filtered frame stops bytes reaching the data register.
    assign rx_ok = !r_reg.receive_sleep_bit && !frame_filtered;
    assign buf_push = r_reg.run && rx_byte_valid && rx_ok;

    // The buffer absorbs a reader stall without losing a received byte.
    vpw_rx_buffer #(
        .WIDTH(vpw_pkg::BYTE_WIDTH)
    ) u_rx_buffer (
        .clock(clock),
        .rstn(rstn),
        .in_valid(buf_push),
        .in_data(rx_byte),
        .in_ready(buf_ready),
        .out_valid(rd_valid),
        .out_data(rd_data),
        .out_ready(rd_ready)
    );

    // Next state of the whole block.
    always_comb begin
        vpw_pkg::vpw_status_type st;
        vpw_pkg::vpw_error_type ev;
        r_next = r_reg;
        st = vpw_pkg::STATUS_RESET;
        ev = err_evt;

        // Disable wins over enable; enable from disabled only reaches suspended.
        if (ctrl_wr) begin
            if (unit_disable_bit) begin
                r_next.mode = vpw_pkg::MODE_DISABLED;
            end else if (unit_enable_bit && r_reg.mode != vpw_pkg::MODE_DISABLED) begin
                r_next.mode = vpw_pkg::MODE_ENABLED;
            end else begin
                r_next.mode = vpw_pkg::MODE_SUSPENDED;
            end
        end

        // After a disable the unit waits for the decoder to see idle.
        if (r_reg.mode == vpw_pkg::MODE_DISABLED) begin
            r_next.wait_idle = 1'b1;
        end else if (dec_sym.eof) begin
            r_next.wait_idle = 1'b0;
        end
        r_next.dec_run = r_next.mode != vpw_pkg::MODE_DISABLED;
        r_next.run = r_next.mode == vpw_pkg::MODE_ENABLED && !r_next.wait_idle;

        // Pin level changes only once the second and third stages agree.
        r_next.sync = {r_reg.sync[1:0], bus_rx_in};
        if (r_reg.sync[1] == r_reg.sync[2]) begin
            r_next.pin_lvl = r_reg.sync[2];
        end
        if (internal_loopback_bit) begin
            r_next.rx_line = enc_tx_level;
        end else begin
            r_next.rx_line = r_reg.pin_lvl ^ receive_polarity_bit;
        end
        r_next.tx_out = internal_loopback_bit ? 1'b0 : enc_tx_level;

        // A shrunken divider must not strand the counter above it, hence >=.
        r_next.tick = 1'b0;
        if (!r_reg.dec_run) begin
            r_next.div_cnt = vpw_pkg::DIV_COUNT_RESET;
        end else if (r_reg.div_cnt >= timing_divider_reg) begin
            r_next.div_cnt = vpw_pkg::DIV_COUNT_RESET;
            r_next.tick = 1'b1;
        end else begin
            r_next.div_cnt = r_reg.div_cnt + 6'h01;
        end

        // Remember whether end-of-frame was the last symbol seen.
        if (dec_sym.eof) begin
            r_next.last_eof = 1'b1;
        end else if (dec_sym.sof || dec_sym.eod || dec_sym.brk || rx_byte_valid) begin
            r_next.last_eof = 1'b0;
        end

        // Sleep entry; a queued in-frame response is dropped on entry.
        r_next.ifr_abort = 1'b0;
        if (r_reg.run && sleep_wr && sleep_wdata && !r_reg.receive_sleep_bit &&
            !(r_reg.last_eof && !r_reg.rx_line)) begin
            r_next.receive_sleep_bit = 1'b1;
            r_next.ifr_abort = in_frame;
        end
        // The clearing symbol wins so a late write cannot sleep through a frame.
        if (dec_sym.eof || dec_sym.brk) begin
            r_next.receive_sleep_bit = 1'b0;
        end

        // Event gating by sleep and filtering.
        if (quiet) begin
            ev = vpw_pkg::ERROR_RESET;
            ev.break_received_flag = err_evt.break_received_flag;
        end
        if (!rx_ok) begin
            ev.receive_overrun_flag = 1'b0;
        end
        st.err = |ev;
        st.lost_arbitration_flag = lost_arb_evt && !quiet;
        st.end_of_data_flag = dec_sym.eod && rx_ok;
        st.end_of_frame_flag = dec_sym.eof;
        st.receive_full_flag = buf_push && buf_ready;
        st.receive_done_flag = rx_done_evt && rx_ok;
        st.transmit_ready_flag = (opcode_free_evt || opcode_taken_evt) && !quiet;
        if (!r_reg.run) begin
            st = vpw_pkg::STATUS_RESET;
            ev = vpw_pkg::ERROR_RESET;
        end

        // Set wins over a clear arriving in the same cycle.
        r_next.status = (r_reg.status & ~status_clr) | st;
        r_next.error = (r_reg.error & ~error_clr) | ev;
        r_next.receive_block_pending = (r_reg.receive_block_pending && !rx_pend_clr) ||
            (r_reg.run && rx_block_done_evt);
        r_next.transmit_block_pending = (r_reg.transmit_block_pending && !tx_pend_clr) ||
            (r_reg.run && tx_block_done_evt);
        if (mask_wr) begin
            r_next.interrupt_mask_reg = mask_wdata;
        end

        // Forced resets while not enabled.
        if (r_reg.mode != vpw_pkg::MODE_ENABLED) begin
            r_next.status = vpw_pkg::STATUS_RESET;
            r_next.error = vpw_pkg::ERROR_RESET;
            r_next.receive_sleep_bit = 1'b0;
        end
        if (r_reg.mode == vpw_pkg::MODE_DISABLED) begin
            r_next.interrupt_mask_reg = vpw_pkg::MASK_RESET;
            r_next.receive_block_pending = 1'b0;
            r_next.transmit_block_pending = 1'b0;
        end
        r_next.irq = r_next.status & r_next.interrupt_mask_reg;

        // Select 0 makes the response with check long, the other short.
        r_next.norm_symbol_with_check = !normalization_select;
        r_next.norm_symbol_no_check = normalization_select;
    end

    // State register; the pin is assumed passive low at reset.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            r_reg <= '{
                mode: vpw_pkg::MODE_DISABLED,
                wait_idle: 1'b1,
                div_cnt: vpw_pkg::DIV_COUNT_RESET,
                status: vpw_pkg::STATUS_RESET,
                error: vpw_pkg::ERROR_RESET,
                interrupt_mask_reg: vpw_pkg::MASK_RESET,
                irq: vpw_pkg::STATUS_RESET,
                norm_symbol_with_check: 1'b1,
                default: '0
            };
        end else begin
            r_reg <= r_next;
        end
    end

    assign bus_tx_out = r_reg.tx_out;
    assign rx_byte_ready = buf_ready;
    assign tick_1us = r_reg.tick;
    assign decoder_run = r_reg.dec_run;
    assign logic_run = r_reg.run;
    assign rx_line = r_reg.rx_line;
    assign mode = r_reg.mode;
    assign receive_sleep_bit = r_reg.receive_sleep_bit;
    assign ifr_abort = r_reg.ifr_abort;
    assign status = r_reg.status;
    assign error = r_reg.error;
    assign interrupt_mask_reg = r_reg.interrupt_mask_reg;
    assign irq_req = r_reg.irq;
    assign receive_block_pending = r_reg.receive_block_pending;
    assign transmit_block_pending = r_reg.transmit_block_pending;
    assign norm_symbol_with_check = r_reg.norm_symbol_with_check;
    assign norm_symbol_no_check = r_reg.norm_symbol_no_check;

    // Helper for the tick spacing check: cycles since the last tick.
    logic [6:0] gap_reg;
    logic gap_ok_reg;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            gap_reg <= 7'h00;
            gap_ok_reg <= 1'b0;
        end else begin
            gap_reg <= r_reg.tick ? 7'h01 : gap_reg + 7'h01;
            gap_ok_reg <= (gap_ok_reg || r_reg.tick) && r_reg.dec_run &&
                $stable(timing_divider_reg);
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    sequence seq_sleep_entry;
        r_reg.run && sleep_wr && sleep_wdata && !r_reg.receive_sleep_bit &&
            !(r_reg.last_eof && !r_reg.rx_line) && !dec_sym.eof && !dec_sym.brk;
    endsequence

    sequence seq_held_suspended;
        (r_reg.mode == vpw_pkg::MODE_SUSPENDED) [*2];
    endsequence

    sequence seq_held_disabled;
        (r_reg.mode == vpw_pkg::MODE_DISABLED) [*2];
    endsequence

    AST_SLEEP_ENTER: assert property (seq_sleep_entry |=> receive_sleep_bit)
        else $error("sleep write not taken");
    AST_SLEEP_QUIET: assert property (quiet && !dec_sym.brk |=>
        !$rose(status.end_of_data_flag))
        else $error("flag raised while sleeping");
    AST_SLEEP_CLEAR: assert property (dec_sym.eof || dec_sym.brk |=> !receive_sleep_bit)
        else $error("sleep not cleared by end symbol");
    AST_SLEEP_IGNORE: assert property (sleep_wr && !receive_sleep_bit && r_reg.last_eof &&
        !r_reg.rx_line |=> !receive_sleep_bit)
        else $error("sleep write accepted at idle");
    AST_IFR_ABORT: assert property (seq_sleep_entry ##0 in_frame |=>
        ifr_abort ##1 !ifr_abort)
        else $error("response abort pulse wrong");
    AST_NORM_FORM: assert property (##1
        norm_symbol_with_check == !$past(normalization_select))
        else $error("normalization form wrong");
    AST_LOOP_PASSIVE: assert property (internal_loopback_bit |=> !bus_tx_out)
        else $error("transmit pin active in loopback");
    AST_TICK_GAP: assert property (r_reg.tick && gap_ok_reg |->
        gap_reg == {1'b0, $past(timing_divider_reg)} + 7'h01)
        else $error("tick spacing wrong");
    AST_SUSP_FORCE: assert property (seq_held_suspended |->
        status == vpw_pkg::STATUS_RESET && error == vpw_pkg::ERROR_RESET && !receive_sleep_bit)
        else $error("suspended state not forced");
    AST_DIS_FORCE: assert property (seq_held_disabled |-> interrupt_mask_reg ==
        vpw_pkg::MASK_RESET && !receive_block_pending && !transmit_block_pending)
        else $error("disabled state not forced");
    AST_EN_REFUSED: assert property (ctrl_wr && mode == vpw_pkg::MODE_DISABLED |=>
        mode != vpw_pkg::MODE_ENABLED)
        else $error("enable taken while disabled");
    AST_ERR_SET: assert property (r_reg.run && rx_ok && |err_evt |=>
        status.err)
        else $error("error status not set");

endmodule

// *** src/vpw_pkg.sv ***
package vpw_pkg;

    // Timing of the symbol tick.
    localparam int CLOCK_HZ = 10000000;
    localparam int TICK_HZ = 1000000;
    localparam logic [5:0] DIVIDER_NOMINAL = 6'(CLOCK_HZ / TICK_HZ - 1);
    localparam logic [5:0] DIV_COUNT_RESET = 6'h00;

    // Pin synchroniser depth and receive buffer depth.
    localparam int SYNC_STAGES = 3;
    localparam int BUF_DEPTH = 2;
    localparam int BYTE_WIDTH = 8;

    // Functional modes selected by the enable and disable bits.
    typedef enum logic [1:0] {
        MODE_DISABLED,
        MODE_SUSPENDED,
        MODE_ENABLED
    } vpw_mode_type;

    // Symbols reported by the decoder.
    typedef struct packed {
        logic sof;
        logic eod;
        logic eof;
        logic brk;
    } vpw_symbol_type;

    // Status flags; the mask and interrupt requests share this layout.
    typedef struct packed {
        logic err;
        logic lost_arbitration_flag;
        logic end_of_data_flag;
        logic end_of_frame_flag;
        logic receive_full_flag;
        logic receive_done_flag;
        logic transmit_ready_flag;
    } vpw_status_type;

    // Error flags.
    typedef struct packed {
        logic transmit_timeout_flag;
        logic transmit_underflow_flag;
        logic receive_overrun_flag;
        logic transmit_aborted_flag;
        logic break_received_flag;
        logic checksum_error_flag;
        logic invalid_frame_flag;
        logic invalid_bit_flag;
    } vpw_error_type;

    localparam vpw_status_type STATUS_RESET = 7'h00;
    localparam vpw_error_type ERROR_RESET = 8'h00;
    localparam vpw_status_type MASK_RESET = 7'h00;

    // Whole state of the control block.
    typedef struct packed {
        vpw_mode_type mode;
        logic wait_idle;
        logic dec_run;
        logic run;
        logic [SYNC_STAGES-1:0] sync;
        logic pin_lvl;
        logic rx_line;
        logic tx_out;
        logic [5:0] div_cnt;
        logic tick;
        logic receive_sleep_bit;
        logic last_eof;
        logic ifr_abort;
        vpw_status_type status;
        vpw_error_type error;
        vpw_status_type interrupt_mask_reg;
        vpw_status_type irq;
        logic receive_block_pending;
        logic transmit_block_pending;
        logic norm_symbol_with_check;
        logic norm_symbol_no_check;
    } vpw_state_type;

endpackage

// *** src/vpw_rx_buffer.sv ***
`timescale 1ns/1ps
module vpw_rx_buffer #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] ent;
        logic [1:0] vld;
        logic rdy;
    } vpw_buf_state_type;

    vpw_buf_state_type r_reg;
    vpw_buf_state_type r_next;
    logic push;
    logic pop;

    // Ready is a flop so a stalled reader holds off the writer cleanly.
    assign push = in_valid && r_reg.rdy;
    assign pop = r_reg.vld[0] && out_ready;

    // Entry 0 is the head; a pop shifts entry 1 forward first.
    always_comb begin
        r_next = r_reg;
        if (pop) begin
            r_next.ent[0] = r_reg.ent[1];
            r_next.vld[0] = r_reg.vld[1];
            r_next.vld[1] = 1'b0;
        end
        if (push) begin
            if (!r_next.vld[0]) begin
                r_next.ent[0] = in_data;
                r_next.vld[0] = 1'b1;
            end else begin
                r_next.ent[1] = in_data;
                r_next.vld[1] = 1'b1;
            end
        end
        r_next.rdy = !r_next.vld[1];
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            r_reg <= '{ent: '0, vld: 2'h0, rdy: 1'b1};
        end else begin
            r_reg <= r_next;
        end
    end

    assign in_ready = r_reg.rdy;
    assign out_valid = r_reg.vld[0];
    assign out_data = r_reg.ent[0];

endmodule

// *** dv/vpw_xcvr_model.sv ***
`timescale 1ns/1ps
// Behavioural bus transceiver: the bus follows the transmit pin after a fixed delay.
// The bus is pulled passive, so a released transmit pin always reads back as passive.
module vpw_xcvr_model #(
    parameter int DELAY_CYCLES = 3
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic tx_pin,
    input wire logic invert,
    output logic rx_pin
);
    logic [DELAY_CYCLES-1:0] line_reg;

    // Delay line standing for the driver, bus and receiver.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            line_reg <= '0;
        end else begin
            line_reg <= {line_reg[DELAY_CYCLES-2:0], tx_pin};
        end
    end

    // The receive sense depends on the fitted part, so it may come out inverted.
    assign rx_pin = line_reg[DELAY_CYCLES-1] ^ invert;
endmodule

// *** dv/test_vpw_control.sv ***
`timescale 1ns/1ps
module test_vpw_control;
    logic clock = 1'b0, rstn = 1'b0, ctrl_wr = 1'b0, unit_enable_bit = 1'b0;
    logic unit_disable_bit = 1'b0, normalization_select = 1'b0, receive_polarity_bit = 1'b0;
    logic internal_loopback_bit = 1'b0, sleep_wr = 1'b0, sleep_wdata = 1'b1, mask_wr = 1'b0;
    logic rx_pend_clr = 1'b0, tx_pend_clr = 1'b0, enc_tx_level = 1'b0, transmitting = 1'b0;
    logic in_frame = 1'b0, lost_arb_evt = 1'b0, rx_done_evt = 1'b0, opcode_free_evt = 1'b0;
    logic opcode_taken_evt = 1'b0, frame_filtered = 1'b0, rx_block_done_evt = 1'b0;
    logic tx_block_done_evt = 1'b0, rx_byte_valid = 1'b0, rd_ready = 1'b1, stall = 1'b0;
    logic [5:0] timing_divider_reg = vpw_pkg::DIVIDER_NOMINAL;
    logic [7:0] rx_byte = 8'h00;
    vpw_pkg::vpw_status_type mask_wdata = 7'h00, status_clr = 7'h00;
    vpw_pkg::vpw_error_type error_clr = 8'h00, err_evt = 8'h00;
    vpw_pkg::vpw_symbol_type dec_sym = 4'h0;
    logic bus_rx_in, bus_tx_out, rx_byte_ready, rd_valid, tick_1us, decoder_run, logic_run;
    logic rx_line, receive_sleep_bit, ifr_abort, receive_block_pending, transmit_block_pending;
    logic norm_symbol_with_check, norm_symbol_no_check;
    logic [7:0] rd_data;
    vpw_pkg::vpw_mode_type mode;
    vpw_pkg::vpw_status_type status, interrupt_mask_reg, irq_req;
    vpw_pkg::vpw_error_type error;
    logic [7:0] exp_q[$];
    int seed = 32'h045ce9dc;
    int bad_count = 0;
    int checked = 0;
    // Status events {symbol, pulses} and the flag each one must raise.
    logic [10:0] ev_tab [6] = '{11'h040, 11'h020, 11'h010, 11'h002, 11'h200, 11'h100};
    logic [6:0] st_tab [6] = '{7'h01, 7'h01, 7'h20, 7'h02, 7'h10, 7'h08};

    vpw_control vpw_control_inst (.clock, .rstn, .ctrl_wr, .unit_enable_bit, .unit_disable_bit,
        .timing_divider_reg, .normalization_select, .receive_polarity_bit,
        .internal_loopback_bit, .sleep_wr, .sleep_wdata, .mask_wr, .mask_wdata, .status_clr,
        .error_clr, .rx_pend_clr, .tx_pend_clr, .bus_rx_in, .bus_tx_out, .enc_tx_level,
        .transmitting, .in_frame, .dec_sym, .err_evt, .lost_arb_evt, .rx_done_evt,
        .opcode_free_evt, .opcode_taken_evt, .frame_filtered, .rx_block_done_evt,
        .tx_block_done_evt, .rx_byte_valid, .rx_byte, .rx_byte_ready, .rd_valid, .rd_data,
        .rd_ready, .tick_1us, .decoder_run, .logic_run, .rx_line, .mode, .receive_sleep_bit,
        .ifr_abort, .status, .error, .interrupt_mask_reg, .irq_req, .receive_block_pending,
        .transmit_block_pending, .norm_symbol_with_check, .norm_symbol_no_check);

    vpw_xcvr_model vpw_xcvr_model_inst (.clock(clock), .rstn(rstn), .tx_pin(bus_tx_out),
        .invert(receive_polarity_bit), .rx_pin(bus_rx_in));

    // Free-running 10 MHz clock.
    initial begin
        forever #50 clock = ~clock;
    end

    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task finish_test;
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Waiting ends just after an edge, so every output read afterwards has settled.
    task cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task ctrl(input logic en, input logic dis);
        @(posedge clock);
        unit_enable_bit <= en;
        unit_disable_bit <= dis;
        ctrl_wr <= 1'b1;
        @(posedge clock);
        ctrl_wr <= 1'b0;
        #1;
    endtask

    // One-cycle pulses: o is {taken, free, lost, tx block, rx block, rx done, sleep write}.
    task pulse(input logic [3:0] s, input logic [7:0] e, input logic [6:0] o);
        @(posedge clock);
        dec_sym <= s;
        err_evt <= e;
        {opcode_taken_evt, opcode_free_evt, lost_arb_evt, tx_block_done_evt,
            rx_block_done_evt, rx_done_evt, sleep_wr} <= o;
        @(posedge clock);
        dec_sym <= 4'h0;
        err_evt <= 8'h00;
        {opcode_taken_evt, opcode_free_evt, lost_arb_evt, tx_block_done_evt,
            rx_block_done_evt, rx_done_evt, sleep_wr} <= 7'h00;
        #1;
    endtask

    task clr;
        @(posedge clock);
        status_clr <= 7'h7f;
        error_clr <= 8'hff;
        @(posedge clock);
        status_clr <= 7'h00;
        error_clr <= 8'h00;
        #1;
    endtask

    // Hands one random byte over; keep says whether it must reach the data register.
    task send_byte(input logic keep);
        logic [7:0] b;
        int n;
        b = 8'($random(seed));
        n = 0;
        @(posedge clock);
        rx_byte_valid <= 1'b1;
        rx_byte <= b;
        do begin
            @(posedge clock);
            n++;
        end while (rx_byte_ready !== 1'b1 && n < 100);
        if (keep) exp_q.push_back(b);
        rx_byte_valid <= 1'b0;
    endtask

    // Measures the spacing of two ticks; the first tick only resynchronises.
    task tick_gap(input logic [5:0] d);
        int n;
        @(posedge clock);
        timing_divider_reg <= d;
        repeat (2) begin
            n = 0;
            do begin
                @(posedge clock);
                #1;
                n++;
            end while (tick_1us !== 1'b1 && n < 200);
        end
        chk(8'(n), 8'(d) + 8'h01, "tick spacing");
    endtask

    // Reader of the data register, stalled at random when asked to.
    always @(posedge clock) begin
        if (stall) rd_ready <= 1'($random(seed));
    end

    // Each word leaving the buffer is matched with the oldest noted byte.
    always @(posedge clock) begin
        if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
            if (exp_q.size() == 0) chk(rd_data, ~rd_data, "unexpected byte");
            else chk(rd_data, exp_q.pop_front(), "received byte");
        end
    end

    // The limit is far above what the sequence needs.
    initial begin
        repeat (30000) @(posedge clock);
        bad_count++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        finish_test;
    end

    initial begin
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        cyc(1);
        chk(8'(mode), 8'(vpw_pkg::MODE_DISABLED), "reset mode");
        chk(8'(bus_tx_out), 8'h00, "reset pin");
        ctrl(1'b1, 1'b1);
        chk(8'(mode), 8'(vpw_pkg::MODE_DISABLED), "both bits set");
        ctrl(1'b1, 1'b0);
        chk(8'(mode), 8'(vpw_pkg::MODE_SUSPENDED), "enable with disable clear");
        chk(8'(decoder_run), 8'h01, "decoder in suspend");
        ctrl(1'b1, 1'b0);
        chk(8'(mode), 8'(vpw_pkg::MODE_ENABLED), "enabled");
        chk(8'(logic_run), 8'h00, "waits for idle");
        pulse(4'h2, 8'h00, 7'h00);
        chk(8'(logic_run), 8'h01, "runs after idle");
        clr;
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            normalization_select <= 1'(i);
            cyc(2);
            chk(8'({norm_symbol_with_check, norm_symbol_no_check}), i ? 8'h01 : 8'h02,
                "normalization forms");
        end
        tick_gap(6'h00);
        tick_gap(6'h03);
        tick_gap(vpw_pkg::DIVIDER_NOMINAL);
        @(posedge clock);
        mask_wr <= 1'b1;
        mask_wdata <= 7'h7f;
        @(posedge clock);
        mask_wr <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            pulse(4'h0, 8'(1 << i), 7'h00);
            chk(8'(error), 8'(1 << i), "error flag");
            chk(8'(irq_req), 8'h40, "error request");
            clr;
        end
        for (int i = 0; i < 6; i++) begin
            pulse(ev_tab[i][10:7], 8'h00, ev_tab[i][6:0]);
            chk(8'(irq_req), 8'(st_tab[i]), "status request");
            clr;
        end
        pulse(4'h0, 8'h00, 7'h01);
        chk(8'(receive_sleep_bit), 8'h00, "sleep after idle");
        pulse(4'h8, 8'h00, 7'h00);
        @(posedge clock);
        in_frame <= 1'b1;
        pulse(4'h0, 8'h00, 7'h01);
        chk(8'({receive_sleep_bit, ifr_abort}), 8'h03, "sleep in frame");
        send_byte(1'b0);
        pulse(4'h4, 8'ha0, 7'h12);
        chk(8'(status), 8'h00, "quiet while asleep");
        pulse(4'h1, 8'h08, 7'h00);
        chk(8'(error), 8'h08, "break while asleep");
        chk(8'({receive_sleep_bit, status}), 8'h40, "break wakes");
        clr;
        pulse(4'h0, 8'h00, 7'h01);
        transmitting <= 1'b1;
        pulse(4'h6, 8'ha0, 7'h12);
        chk(8'({receive_sleep_bit, status}), 8'h68, "end of frame wakes");
        @(posedge clock);
        in_frame <= 1'b0;
        clr;
        pulse(4'h8, 8'h00, 7'h00);
        rd_ready <= 1'b0;
        send_byte(1'b1);
        send_byte(1'b1);
        cyc(2);
        chk(8'({rx_byte_ready, status}), 8'h04, "buffer full");
        stall = 1'b1;
        send_byte(1'b1);
        cyc(20);
        stall = 1'b0;
        @(posedge clock);
        rd_ready <= 1'b1;
        cyc(4);
        chk(8'(exp_q.size()), 8'h00, "buffer drained");
        // The loopback switch is only moved while suspended, to keep edges off the stopped logic; the decoder still runs.
        ctrl(1'b0, 1'b0);
        internal_loopback_bit <= 1'b1;
        ctrl(1'b1, 1'b0);
        @(posedge clock);
        enc_tx_level <= 1'b1;
        cyc(3);
        chk(8'({bus_tx_out, rx_line}), 8'h01, "loopback high");
        enc_tx_level <= 1'b0;
        cyc(3);
        chk(8'(rx_line), 8'h00, "loopback low");
        ctrl(1'b0, 1'b0);
        internal_loopback_bit <= 1'b0;
        ctrl(1'b1, 1'b0);
        for (int p = 0; p < 2; p++) begin
            @(posedge clock);
            receive_polarity_bit <= 1'(p);
            enc_tx_level <= 1'b1;
            cyc(2);
            chk(8'(bus_tx_out), 8'h01, "pin driven");
            cyc(10);
            chk(8'(rx_line), 8'h01, "line active");
            enc_tx_level <= 1'b0;
            cyc(12);
            chk(8'(rx_line), 8'h00, "line passive");
        end
        pulse(4'h0, 8'h80, 7'h0c);
        chk(8'({receive_block_pending, transmit_block_pending}), 8'h03, "pendings");
        ctrl(1'b0, 1'b0);
        cyc(1);
        chk(error | 8'(status), 8'h00, "suspend clears");
        chk(8'(interrupt_mask_reg), 8'h7f, "suspend keeps mask");
        chk(8'({decoder_run, logic_run}), 8'h02, "suspend runs decoder");
        ctrl(1'b0, 1'b1);
        cyc(6);
        chk(8'(interrupt_mask_reg), 8'h00, "disable clears mask");
        chk(8'({receive_block_pending, transmit_block_pending}), 8'h00, "disable pend");
        chk(8'(decoder_run), 8'h00, "decoder stopped");
        finish_test;
    end
endmodule
